// [ncb_pkg.sv]
// Package for the network cyclic configuration bank.
// Assumes a 200 MHz system clock and a simple strobe register port.
package ncb_pkg;

  // ----------------------------------------------------------------
  // Register offsets (word index on the plain port)
  // ----------------------------------------------------------------
  localparam logic [5:0] ADR_BIT_RATE  = 6'h00;
  localparam logic [5:0] ADR_SYNC_RATE = 6'h01;
  localparam logic [5:0] ADR_CH1_DEST  = 6'h02;
  localparam logic [5:0] ADR_CH1_SRC   = 6'h03;
  localparam logic [5:0] ADR_CH2_DEST  = 6'h04;
  localparam logic [5:0] ADR_CH2_SRC   = 6'h05;
  localparam logic [5:0] ADR_CH3_DEST  = 6'h06;
  localparam logic [5:0] ADR_CH3_SRC   = 6'h07;
  localparam logic [5:0] ADR_IN1_TGT   = 6'h08;
  localparam logic [5:0] ADR_IN2_TGT   = 6'h09;
  localparam logic [5:0] ADR_IN3_TGT   = 6'h0A;
  localparam logic [5:0] ADR_EVT_SEL   = 6'h0B;
  localparam logic [5:0] ADR_DIAG      = 6'h0C;
  localparam logic [5:0] ADR_DL_REJECT = 6'h0D;
  localparam logic [5:0] ADR_MOT_INH   = 6'h0E;
  localparam logic [5:0] ADR_SYNC_STAT = 6'h0F;
  localparam logic [5:0] ADR_NODE_ADDR = 6'h10;
  localparam logic [5:0] ADR_TRIP_EN   = 6'h11;
  localparam logic [5:0] ADR_DECODED   = 6'h12;
  localparam logic [5:0] ADR_IRQ_STAT  = 6'h13;
  localparam logic [5:0] ADR_IRQ_EN    = 6'h14;
  localparam logic [5:0] ADR_IRQ_CLR   = 6'h15;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  RST_BIT_RATE  = 2'h1;
  localparam logic [15:0] DIAG_NO_DATA  = 16'h0000;
  localparam logic [15:0] DIAG_RECONFIG = 16'hFFFF;
  localparam logic [15:0] DIAG_INIT_ERR = 16'hFFFE;
  localparam logic [15:0] DIAG_SELF_RCF = 16'hFFFD;
  localparam logic [15:0] DIAG_MAX_CNT  = 16'h7FFF;
  localparam logic [7:0]  TRIP_DL_REJ   = 8'h46;
  localparam logic [7:0]  TRIP_MOTION   = 8'h51;
  localparam logic [1:0]  SYNC_NOT_MST  = 2'h0;
  localparam logic [1:0]  SYNC_MASTER   = 2'h1;
  localparam logic [1:0]  SYNC_MST_BAD  = 2'h3;
  localparam int          IRQ_BITS      = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ        = 200000000;
  localparam longint DIAG_PERIOD_S = 1;
  localparam longint DIAG_CYCLES   = CLK_HZ * DIAG_PERIOD_S;
  localparam longint CYC_PER_MS    = CLK_HZ / 1000;

  typedef enum logic [1:0] {
    RATE_5M    = 2'b00,
    RATE_2M5   = 2'b01,
    RATE_1M25  = 2'b10,
    RATE_625K  = 2'b11
  } ncb_rate_type;

endpackage

// [ncb_bcd_split.sv]
// Decimal split of a setting into its upper digits and its low two digits.
// Assumes a purely combinational use inside the bank.
`timescale 1ns/1ps
`default_nettype none
module ncb_bcd_split #(
  parameter int W = 15
) (
  input  wire logic [W-1:0] value,
  output logic      [W-1:0] upper,
  output logic      [6:0]   lower
);
  // ----------------------------------------------------------------
  // Divide by one hundred
  // ----------------------------------------------------------------
  // Constant divisor lets synthesis build a small multiplier network
  always_comb begin
    upper = W'(value / W'(100));
    lower = 7'(value % W'(100));
  end
endmodule
`default_nettype wire

// [ncb_bank.sv]
// Network cyclic configuration bank: settings, decode, diagnostics, trips.
// Assumes the link engine and the drive supply same-clock event pulses.
//
// Behaviour
// - Bit-rate code 0..3 selects 5, 2.5, 1.25 Mbit/s or 625 kbit/s.
// - Sync setting low two digits fast period ms, high two slow multiple.
// - Easy-mode channels need only the fast period digits.
// - Destination decodes into node 0..255 and slot 1..3.
// - Source decodes into menu and parameter; value is transmitted.
// - Three outgoing channels; incoming slots write their target parameters.
// - Event select 0 schedules nothing; 1..4 schedule tasks one to four.
// - Event task scheduled on received or self-generated sync.
// - Diagnostics refreshed each second with messages per second.
// - Codes 0 no data, -1 reconfig, -2 init fail, -3 self reconfig.
// - Download refused when reject set and drive enabled; trip 70 if enabled.
// - Motion-core error trips 81 unless inhibit setting is one.
// - Sync status 0 not master, 1 master, 3 master with bad sync.
// - Node address zero disables network participation.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ncb_bank
  import ncb_pkg::*;
#(
  parameter longint DIAG_CYC = ncb_pkg::DIAG_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  input  wire logic        initPulse,
  input  wire logic        rxSync,
  input  wire logic        rxMessage,
  input  wire logic        ringActive,
  input  wire logic        reconfigDetected,
  input  wire logic        selfForcedReconfig,
  input  wire logic        initFail,
  input  wire logic        downloadReq,
  input  wire logic        driveEnabled,
  input  wire logic        motionCoreError,
  input  wire logic        syncMasterReq,
  input  wire logic        syncFreqOk,
  output logic             netEnable,
  output logic      [1:0]  bitRate,
  output logic      [6:0]  fastPeriodMs,
  output logic      [6:0]  slowMultiple,
  output logic             syncGenPulse,
  output logic      [3:0]  eventTaskPulse,
  output logic             downloadAccept,
  output logic             downloadRefused,
  output logic             tripPulse,
  output logic      [7:0]  tripCode,
  output logic      [1:0]  syncStatus,
  output logic      [7:0]  chNode [3],
  output logic      [1:0]  chSlot [3],
  output logic      [6:0]  chMenu [3],
  output logic      [6:0]  chParam [3],
  output logic      [6:0]  inMenu [3],
  output logic      [6:0]  inParam [3],
  output logic             irq
);
  import ncb_pkg::*;

  // ----------------------------------------------------------------
  // Software-written settings
  // ----------------------------------------------------------------
  logic [1:0]  bitRate_ff;
  logic [13:0] syncRate_ff;
  logic [14:0] dest_ff [3];
  logic [13:0] src_ff [3];
  logic [13:0] inTgt_ff [3];
  logic [2:0]  evtSel_ff;
  logic        dlReject_ff;
  logic        motInh_ff;
  logic [7:0]  nodeAddr_ff;
  logic        tripEn_ff;
  logic [IRQ_BITS-1:0] irqEn_ff;

  // Write decoding used by several processes
  function automatic logic wr_hit(input logic [5:0] a, input logic [5:0] t);
    return a == t;
  endfunction

  // Plain settings; live copies, all but trip enable and interrupt enable latched below at initialisation
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bitRate_ff  <= RST_BIT_RATE;
      syncRate_ff <= '0;
      evtSel_ff   <= '0;
      dlReject_ff <= 1'b0;
      motInh_ff   <= 1'b0;
      nodeAddr_ff <= '0;
      tripEn_ff   <= 1'b0;
      irqEn_ff    <= '0;
      for (int i = 0; i < 3; i++) begin
        dest_ff[i]  <= '0;
        src_ff[i]   <= '0;
        inTgt_ff[i] <= '0;
      end
    end else if (regWrite) begin
      if (wr_hit(regAddr, ADR_BIT_RATE))  bitRate_ff  <= regWrData[1:0];
      if (wr_hit(regAddr, ADR_SYNC_RATE)) syncRate_ff <= regWrData[13:0];
      if (wr_hit(regAddr, ADR_EVT_SEL))   evtSel_ff   <= regWrData[2:0];
      if (wr_hit(regAddr, ADR_DL_REJECT)) dlReject_ff <= regWrData[0];
      if (wr_hit(regAddr, ADR_MOT_INH))   motInh_ff   <= regWrData[0];
      if (wr_hit(regAddr, ADR_NODE_ADDR)) nodeAddr_ff <= regWrData[7:0];
      if (wr_hit(regAddr, ADR_TRIP_EN))   tripEn_ff   <= regWrData[0];
      if (wr_hit(regAddr, ADR_IRQ_EN)) irqEn_ff <= regWrData[IRQ_BITS-1:0];
      for (int i = 0; i < 3; i++) begin
        if (wr_hit(regAddr, 6'(ADR_CH1_DEST + 2 * i)))
          dest_ff[i] <= regWrData[14:0];
        if (wr_hit(regAddr, 6'(ADR_CH1_SRC + 2 * i)))
          src_ff[i] <= regWrData[13:0];
        if (wr_hit(regAddr, 6'(ADR_IN1_TGT + i)))
          inTgt_ff[i] <= regWrData[13:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Latched at initialisation
  // ----------------------------------------------------------------
  // Settings other than trip enable and interrupt enable take effect only at init so a live link never sees a glitch
  logic [1:0]  actRate_ff;
  logic [13:0] actSync_ff;
  logic [2:0]  actEvt_ff;
  logic        actDlRej_ff;
  logic        actMotInh_ff;
  logic        actNet_ff;
  logic [14:0] actDest_ff [3];
  logic [13:0] actSrc_ff [3];
  logic [13:0] actIn_ff [3];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      actRate_ff   <= RST_BIT_RATE;
      actSync_ff   <= '0;
      actEvt_ff    <= '0;
      actDlRej_ff  <= 1'b0;
      actMotInh_ff <= 1'b0;
      actNet_ff    <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        actDest_ff[i] <= '0;
        actSrc_ff[i]  <= '0;
        actIn_ff[i]   <= '0;
      end
    end else if (initPulse) begin
      actRate_ff   <= bitRate_ff;
      actSync_ff   <= syncRate_ff;
      actEvt_ff    <= evtSel_ff;
      actDlRej_ff  <= dlReject_ff;
      actMotInh_ff <= motInh_ff;
      actNet_ff    <= nodeAddr_ff != 8'h00;
      for (int i = 0; i < 3; i++) begin
        actDest_ff[i] <= dest_ff[i];
        actSrc_ff[i]  <= src_ff[i];
        actIn_ff[i]   <= inTgt_ff[i];
      end
    end
  end

  assign netEnable = actNet_ff;
  assign bitRate   = actRate_ff;

  // ----------------------------------------------------------------
  // Decimal decode of sync and easy-mode settings
  // ----------------------------------------------------------------
  logic [13:0] syncUpper;
  logic [14:0] destUpper [3];
  logic [6:0]  destLower [3];
  logic [13:0] srcUpper [3];
  logic [6:0]  srcLower [3];
  logic [13:0] inUpper [3];
  logic [6:0]  inLower [3];

  ncb_bcd_split #(.W(14)) uSync (
    .value(actSync_ff),
    .upper(syncUpper),
    .lower(fastPeriodMs)
  );
  assign slowMultiple = syncUpper[6:0];

  // Same split repeated for each of the three channels
  for (genvar g = 0; g < 3; g++) begin : gChan
    ncb_bcd_split #(.W(15)) uDest (
      .value(actDest_ff[g]),
      .upper(destUpper[g]),
      .lower(destLower[g])
    );
    ncb_bcd_split #(.W(14)) uSrc (
      .value(actSrc_ff[g]),
      .upper(srcUpper[g]),
      .lower(srcLower[g])
    );
    ncb_bcd_split #(.W(14)) uIn (
      .value(actIn_ff[g]),
      .upper(inUpper[g]),
      .lower(inLower[g])
    );
    assign chNode[g]  = destUpper[g][7:0];
    assign chSlot[g]  = destLower[g][1:0];
    assign chMenu[g]  = srcUpper[g][6:0];
    assign chParam[g] = srcLower[g];
    assign inMenu[g]  = inUpper[g][6:0];
    assign inParam[g] = inLower[g];
  end

  // ----------------------------------------------------------------
  // Sync generation as master
  // ----------------------------------------------------------------
  // Only a node with a nonzero fast period acts as sync source
  logic [31:0] syncCnt_ff;
  logic        syncGen;
  assign syncGen = actNet_ff && fastPeriodMs != 7'h00 &&
                   syncCnt_ff == 32'(fastPeriodMs * CYC_PER_MS - 1);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !actNet_ff || initPulse) syncCnt_ff <= '0;
    else if (syncGen)                      syncCnt_ff <= '0;
    else syncCnt_ff <= syncCnt_ff + 32'h0000_0001;
  end
  assign syncGenPulse = syncGen;

  // ----------------------------------------------------------------
  // Event task scheduling
  // ----------------------------------------------------------------
  logic [3:0] evtPulse_ff;
  logic       syncAny;
  assign syncAny = actNet_ff && (rxSync || syncGen);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) evtPulse_ff <= '0;
    else begin
      evtPulse_ff <= '0;
      if (syncAny && actEvt_ff != 3'h0 && actEvt_ff <= 3'h4)
        evtPulse_ff[2'(actEvt_ff - 3'h1)] <= 1'b1;
    end
  end
  assign eventTaskPulse = evtPulse_ff;

  // Event pulse follows the causing sync by exactly one cycle
  a_event_after_sync: assert property (@(posedge sys_clk) disable iff (!rst_n)
    syncAny && actEvt_ff == 3'h2 |=> eventTaskPulse == 4'b0010)
    else $error("event task not scheduled on sync");

  a_event_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !syncAny |=> eventTaskPulse == 4'h0)
    else $error("event task without a sync");

  // ----------------------------------------------------------------
  // Diagnostics
  // ----------------------------------------------------------------
  logic [31:0] secCnt_ff;
  logic [15:0] msgCnt_ff;
  logic [15:0] diag_ff;
  logic        secTick;
  assign secTick = secCnt_ff == 32'(DIAG_CYC - 1);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || secTick) secCnt_ff <= '0;
    else                   secCnt_ff <= secCnt_ff + 32'h0000_0001;
  end

  // Count saturates so the reported value never turns negative
  always_ff @(posedge sys_clk) begin
    if (!rst_n || secTick) msgCnt_ff <= '0;
    else if (rxMessage && actNet_ff && msgCnt_ff != DIAG_MAX_CNT)
      msgCnt_ff <= msgCnt_ff + 16'h0001;
  end

  // Error codes take priority over the message count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) diag_ff <= DIAG_NO_DATA;
    else if (secTick) begin
      if (initFail)                diag_ff <= DIAG_INIT_ERR;
      else if (selfForcedReconfig) diag_ff <= DIAG_SELF_RCF;
      else if (reconfigDetected)   diag_ff <= DIAG_RECONFIG;
      else if (ringActive)         diag_ff <= msgCnt_ff;
      else                         diag_ff <= DIAG_NO_DATA;
    end
  end

  a_diag_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !secTick |=> $stable(diag_ff))
    else $error("diagnostics changed between refreshes");

  // ----------------------------------------------------------------
  // Download interlock and trips
  // ----------------------------------------------------------------
  logic       refuse;
  logic       motTrip;
  logic       trip_ff;
  logic [7:0] tripCode_ff;
  assign refuse  = downloadReq && actDlRej_ff && driveEnabled;
  assign motTrip = motionCoreError && !actMotInh_ff;
  assign downloadAccept  = downloadReq && !refuse;
  assign downloadRefused = refuse;

  // Motion trip wins when both happen in one cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trip_ff     <= 1'b0;
      tripCode_ff <= '0;
    end else begin
      trip_ff <= motTrip || (refuse && tripEn_ff);
      if (motTrip)                tripCode_ff <= TRIP_MOTION;
      else if (refuse && tripEn_ff) tripCode_ff <= TRIP_DL_REJ;
    end
  end
  assign tripPulse = trip_ff;
  assign tripCode  = tripCode_ff;

  a_dl_trip: assert property (@(posedge sys_clk) disable iff (!rst_n)
    refuse && tripEn_ff && !motTrip |=> tripPulse && tripCode == 8'h46)
    else $error("download refusal did not trip");

  a_dl_notrip: assert property (@(posedge sys_clk) disable iff (!rst_n)
    refuse && !tripEn_ff && !motTrip |=> !tripPulse)
    else $error("trip raised with trips disabled");

  a_motion_trip: assert property (@(posedge sys_clk) disable iff (!rst_n)
    motionCoreError && !(refuse && tripEn_ff)
      |=> tripPulse == !$past(actMotInh_ff))
    else $error("motion trip policy broken");

  // ----------------------------------------------------------------
  // Sync master status
  // ----------------------------------------------------------------
  logic [1:0] syncStat_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_n)              syncStat_ff <= SYNC_NOT_MST;
    else if (!syncMasterReq) syncStat_ff <= SYNC_NOT_MST;
    else if (!syncFreqOk)    syncStat_ff <= SYNC_MST_BAD;
    else                     syncStat_ff <= SYNC_MASTER;
  end
  assign syncStatus = syncStat_ff;

  a_sync_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
    syncMasterReq && !syncFreqOk |=> syncStatus == 2'h3)
    else $error("bad sync frequency not reported");

  // ----------------------------------------------------------------
  // Interrupts: sync, refusal, motion trip, diagnostic refresh
  // ----------------------------------------------------------------
  logic [IRQ_BITS-1:0] irqStat_ff;
  logic [IRQ_BITS-1:0] irqSet;
  logic [IRQ_BITS-1:0] irqClr;
  assign irqSet = {secTick, motTrip, refuse, syncAny};
  assign irqClr = (regWrite && wr_hit(regAddr, ADR_IRQ_CLR)) ?
                  regWrData[IRQ_BITS-1:0] : '0;

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) irqStat_ff <= '0;
    else        irqStat_ff <= (irqStat_ff & ~irqClr) | irqSet;
  end
  assign irq = |(irqStat_ff & irqEn_ff);

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [31:0] rd_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) rd_ff <= '0;
    else if (regRead) begin
      rd_ff <= '0;
      unique case (regAddr)
        ADR_BIT_RATE:  rd_ff <= 32'(bitRate_ff);
        ADR_SYNC_RATE: rd_ff <= 32'(syncRate_ff);
        ADR_CH1_DEST:  rd_ff <= 32'(dest_ff[0]);
        ADR_CH1_SRC:   rd_ff <= 32'(src_ff[0]);
        ADR_CH2_DEST:  rd_ff <= 32'(dest_ff[1]);
        ADR_CH2_SRC:   rd_ff <= 32'(src_ff[1]);
        ADR_CH3_DEST:  rd_ff <= 32'(dest_ff[2]);
        ADR_CH3_SRC:   rd_ff <= 32'(src_ff[2]);
        ADR_IN1_TGT:   rd_ff <= 32'(inTgt_ff[0]);
        ADR_IN2_TGT:   rd_ff <= 32'(inTgt_ff[1]);
        ADR_IN3_TGT:   rd_ff <= 32'(inTgt_ff[2]);
        ADR_EVT_SEL:   rd_ff <= 32'(evtSel_ff);
        ADR_DIAG:      rd_ff <= 32'(diag_ff);
        ADR_DL_REJECT: rd_ff <= 32'(dlReject_ff);
        ADR_MOT_INH:   rd_ff <= 32'(motInh_ff);
        ADR_SYNC_STAT: rd_ff <= 32'(syncStat_ff);
        ADR_NODE_ADDR: rd_ff <= 32'(nodeAddr_ff);
        ADR_TRIP_EN:   rd_ff <= 32'(tripEn_ff);
        ADR_DECODED:   rd_ff <= {actNet_ff, 1'b0, actRate_ff,
                                 5'h00, slowMultiple, 9'h000, fastPeriodMs};
        ADR_IRQ_STAT:  rd_ff <= 32'(irqStat_ff);
        ADR_IRQ_EN:    rd_ff <= 32'(irqEn_ff);
        default:       rd_ff <= '0;
      endcase
    end
  end
  assign regRdData = rd_ff;

endmodule
`default_nettype wire

// [ncb_net_model.sv]
// Model of the other ring nodes: one sync master and message traffic.
// Assumes the bank under test shares sys_clk with the link engine.
`timescale 1ns/1ps
`default_nettype none
module ncb_net_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       syncReq,
  input  wire logic [3:0] syncLat,
  input  wire logic       msgGo,
  input  wire logic [7:0] msgCount,
  output logic            rxSync,
  output logic            rxMessage
);
  logic [3:0] syncCnt_ff;
  logic [7:0] msgLeft_ff;
  logic       gap_ff;

  // ------------------------------------------------------------
  // Sync master: the only source of rxSync, fired a chosen latency after each request
  // ------------------------------------------------------------
  // Latency is chosen per request so prompt and slow masters are seen
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      syncCnt_ff <= 4'h0;
      rxSync     <= 1'b0;
    end else begin
      rxSync <= (syncCnt_ff == 4'h1);
      if (syncReq)
        syncCnt_ff <= syncLat;
      else if (syncCnt_ff != 4'h0)
        syncCnt_ff <= syncCnt_ff - 4'h1;
    end
  end

  // Data messages, one every other cycle, counted down from a burst
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      msgLeft_ff <= 8'h00;
      gap_ff     <= 1'b0;
      rxMessage  <= 1'b0;
    end else begin
      rxMessage <= (msgLeft_ff != 8'h00) && !gap_ff;
      gap_ff    <= !gap_ff;
      if (msgGo)
        msgLeft_ff <= msgCount;
      else if (msgLeft_ff != 8'h00 && !gap_ff)
        msgLeft_ff <= msgLeft_ff - 8'h01;
    end
  end
endmodule
`default_nettype wire

// [test_ncb_bank.sv]
// Self-checking bench for the bank: random settings plus corner cases.
// Assumes the diagnostic second is shortened to 100 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_ncb_bank;
  import ncb_pkg::*;
  logic        sys_clk, rst_n, regWrite, regRead, initPulse, rxSync;
  logic        rxMessage, ringActive, reconfigDetected, selfForcedReconfig;
  logic        initFail, downloadReq, driveEnabled, motionCoreError;
  logic        syncMasterReq, syncFreqOk, netEnable, syncGenPulse, irq;
  logic        downloadAccept, downloadRefused, tripPulse, syncReq, msgGo;
  logic [5:0]  regAddr;
  logic [31:0] regWrData, regRdData, rdVal, seed;
  logic [1:0]  bitRate, syncStatus;
  logic [6:0]  fastPeriodMs, slowMultiple;
  logic [3:0]  eventTaskPulse, syncLat;
  logic [7:0]  tripCode, msgCount;
  logic [7:0]  chNode [3];
  logic [1:0]  chSlot [3];
  logic [6:0]  chMenu [3], chParam [3], inMenu [3], inParam [3];
  int          badCount, comparisons, cycles, v, node, slot, mp, n;

  ncb_bank #(.DIAG_CYC(100)) i_dut (.sys_clk, .rst_n, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .initPulse, .rxSync, .rxMessage,
    .ringActive, .reconfigDetected, .selfForcedReconfig, .initFail,
    .downloadReq, .driveEnabled, .motionCoreError, .syncMasterReq,
    .syncFreqOk, .netEnable, .bitRate, .fastPeriodMs, .slowMultiple,
    .syncGenPulse, .eventTaskPulse, .downloadAccept, .downloadRefused,
    .tripPulse, .tripCode, .syncStatus, .chNode, .chSlot, .chMenu,
    .chParam, .inMenu, .inParam, .irq);
  ncb_net_model i_net (.sys_clk, .rst_n, .syncReq, .syncLat, .msgGo,
    .msgCount, .rxSync, .rxMessage);

  // ------------------------------------------------------------
  // Helpers: random source, expectations, bus cycles
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] evtExp(int s);
    return (s == 0) ? 4'h0 : 4'(1 << (s - 1));
  endfunction
  function automatic logic [1:0] stExp(logic r, logic ok);
    return !r ? SYNC_NOT_MST : ok ? SYNC_MASTER : SYNC_MST_BAD;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(logic [5:0] a, int d);
    @(posedge sys_clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= 32'(d);
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  // Data stand from the cycle after the strobe until the next read, so sample right there
  task automatic rd(logic [5:0] a);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 rdVal = regRdData;
  endtask
  task automatic init();
    @(posedge sys_clk);
    initPulse <= 1'b1;
    @(posedge sys_clk);
    initPulse <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // Clear the refresh flag, then wait a bounded time for the next second
  task automatic waitTick();
    wr(ADR_IRQ_CLR, 8);
    @(posedge sys_clk);
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    chk(irq, 1, "tick irq");
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      badCount++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    {rst_n, regWrite, regRead, initPulse, ringActive, reconfigDetected,
     selfForcedReconfig, initFail, downloadReq, driveEnabled, syncReq,
     motionCoreError, syncMasterReq, syncFreqOk, msgGo, regAddr,
     regWrData, syncLat, msgCount} = '0;
    seed = 32'd46;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ADR_BIT_RATE);
    chk(rdVal, 32'(RST_BIT_RATE), "rate reset");
    rd(6'h3F);
    chk(rdVal, 0, "unmapped");
    for (int i = 0; i < 4; i++) begin
      wr(ADR_BIT_RATE, i);
      init();
      chk(bitRate, i, "rate out");
      rd(ADR_DECODED);
      chk(rdVal[29:28], i, "rate decoded");
    end
    $display("done: bit rate");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 1510 : (i == 1) ? 9999 : (xs() % 100) * 100 + xs() % 100;
      wr(ADR_SYNC_RATE, v);
      init();
      chk(fastPeriodMs, v % 100, "fast");
      chk(slowMultiple, v / 100, "slow");
    end
    $display("done: sync split");
    for (int c = 0; c < 3; c++) begin
      node = (c == 0) ? 255 : int'(xs() % 256);
      slot = 1 + int'(xs() % 3);
      mp = int'(xs() % 10000);
      wr(ADR_CH1_DEST + 6'(2 * c), node * 100 + slot);
      wr(ADR_CH1_SRC + 6'(2 * c), mp);
      wr(ADR_IN1_TGT + 6'(c), 9999 - mp);
      init();
      chk(chNode[c], node, "node");
      chk(chSlot[c], slot, "slot");
      chk(chMenu[c], mp / 100, "src menu");
      chk(chParam[c], mp % 100, "src param");
      chk(inMenu[c], (9999 - mp) / 100, "in menu");
      chk(inParam[c], (9999 - mp) % 100, "in param");
    end
    $display("done: channels");
    chk(netEnable, 0, "net off");
    wr(ADR_NODE_ADDR, 7);
    init();
    chk(netEnable, 1, "net on");
    for (int s = 0; s < 5; s++) begin
      wr(ADR_EVT_SEL, s);
      init();
      @(posedge sys_clk);
      syncLat <= 4'(1 + xs() % 8);
      syncReq <= 1'b1;
      @(posedge sys_clk);
      syncReq <= 1'b0;
      n = 0;
      while (rxSync !== 1'b1 && n < 20) begin
        @(posedge sys_clk);
        #1 n++;
      end
      @(posedge sys_clk);
      #1 chk(eventTaskPulse, evtExp(s), "event task");
    end
    $display("done: events");
    wr(ADR_SYNC_RATE, 0);
    init();
    chk(syncGenPulse, 0, "own sync off");
    wr(ADR_IRQ_EN, 8);
    @(posedge sys_clk);
    ringActive <= 1'b1;
    msgCount   <= 8'h0A;
    waitTick();
    @(posedge sys_clk);
    msgGo <= 1'b1;
    @(posedge sys_clk);
    msgGo <= 1'b0;
    waitTick();
    rd(ADR_DIAG);
    chk(rdVal[15:0], 10, "msg count");
    waitTick();
    rd(ADR_DIAG);
    chk(rdVal[15:0], DIAG_NO_DATA, "no data");
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      reconfigDetected   <= (k == 0);
      selfForcedReconfig <= (k == 1);
      initFail           <= (k == 2);
      waitTick();
      rd(ADR_DIAG);
      chk(rdVal[15:0], (k == 0) ? DIAG_RECONFIG : (k == 1) ? DIAG_SELF_RCF
          : DIAG_INIT_ERR, "diag code");
    end
    // Masked: the status bit still sets but the line stays low
    wr(ADR_IRQ_EN, 0);
    repeat (110) @(posedge sys_clk);
    #1 chk(irq, 0, "irq masked");
    rd(ADR_IRQ_STAT);
    chk(rdVal[3], 1, "irq status");
    $display("done: diagnostics");
    for (int k = 0; k < 8; k++) begin
      wr(ADR_DL_REJECT, k & 1);
      wr(ADR_TRIP_EN, (k >> 1) & 1);
      init();
      @(posedge sys_clk);
      driveEnabled <= k[2];
      downloadReq  <= 1'b1;
      #1 chk(downloadRefused, k[0] & k[2], "refused");
      chk(downloadAccept, !(k[0] & k[2]), "accept");
      @(posedge sys_clk);
      downloadReq <= 1'b0;
      #1 chk(tripPulse, k == 7, "dl trip");
      if (k == 7)
        chk(tripCode, TRIP_DL_REJ, "dl code");
    end
    for (int k = 0; k < 2; k++) begin
      wr(ADR_MOT_INH, k);
      init();
      @(posedge sys_clk);
      motionCoreError <= 1'b1;
      @(posedge sys_clk);
      motionCoreError <= 1'b0;
      #1 chk(tripPulse, k == 0, "motion trip");
      if (k == 0)
        chk(tripCode, TRIP_MOTION, "motion code");
    end
    $display("done: trips");
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      syncMasterReq <= k[0];
      syncFreqOk    <= k[1];
      repeat (3) @(posedge sys_clk);
      #1 chk(syncStatus, stExp(k[0], k[1]), "sync status");
    end
    $display("done: sync status");
    final_report();
  end
endmodule
`default_nettype wire
